// *** core/qrl_defs.vh ***
// constants for the queued read and log read command decoder
`ifndef QRL_DEFS_VH
`define QRL_DEFS_VH
// command codes
`define QRL_CMD_QUEUED_READ 8'h60
`define QRL_CMD_LOG_READ 8'h2F
// avalon register word offsets (byte address = 4 * index)
`define QRL_REG_FEAT 4'h0
`define QRL_REG_SCNT 4'h1
`define QRL_REG_SNUM 4'h2
`define QRL_REG_CLOW 4'h3
`define QRL_REG_CHIGH 4'h4
`define QRL_REG_DEVHEAD 4'h5
`define QRL_REG_CMD 4'h6
`define QRL_REG_CTRL 4'h7
`define QRL_REG_STATUS 4'h8
`define QRL_REG_ERRADDR 4'h9
`define QRL_REG_LOGINFO 4'hA
`define QRL_REG_LIMIT 4'hB
`define QRL_REG_DEADLINE 4'hC
// field positions
`define QRL_TAG_HI 7
`define QRL_TAG_LO 3
`define QRL_RBA_BIT 0
`define QRL_QUEUED_PRIORITY_HI 7
`define QRL_QUEUED_PRIORITY_LO 6
`define QRL_FUA_BIT 7
`define QRL_ICC_COARSE_BIT 7
`define QRL_CTRL_HOB_BIT 0
`define QRL_CTRL_RBA_SUP_BIT 1
`define QRL_CTRL_RBA_EN_BIT 2
`define QRL_CTRL_DLABORT_BIT 3
`define QRL_CTRL_FEAT_LO 8
`define QRL_CTRL_FEAT_HI 15
// priority encodings
`define QRL_QUEUED_PRIORITY_NORMAL 2'h0
`define QRL_QUEUED_PRIORITY_ISOCH 2'h1
`define QRL_QUEUED_PRIORITY_HIGH 2'h2
// log addresses
`define QRL_LOG_DIR 8'h00
`define QRL_LOG_ERR 8'h03
`define QRL_LOG_STSHORT 8'h06
`define QRL_LOG_STEXT 8'h07
`define QRL_LOG_POWER 8'h08
`define QRL_LOG_QERR 8'h10
`define QRL_LOG_LINK 8'h11
`define QRL_LOG_QMGMT 8'h12
`define QRL_LOG_REBUILD 8'h15
`define QRL_LOG_WSTRM 8'h21
`define QRL_LOG_RSTRM 8'h22
`define QRL_LOG_IDENT 8'h30
`define QRL_LOG_HOST_LO 8'h80
`define QRL_LOG_HOST_HI 8'h9F
`define QRL_HOST_LOG_LEN 17'h00010
// reset values
`define QRL_CTRL_RESET 16'hFF00
// deadline timing
`define QRL_FINE_MS 10
`define QRL_COARSE_MS 500
`define QRL_CLOCK_MHZ 200
`define QRL_CYC_PER_MS (`QRL_CLOCK_MHZ * 1000)
`endif

// *** core/qrl_log_map.v ***
// log address map: feature set, length and validity of each log
`timescale 1ns/1ps
`include "qrl_defs.vh"
module qrl_log_map (
    input wire [7:0] log_addr,
    input wire [7:0] feature_on,
    output reg known,
    output reg feat_ok,
    output reg [16:0] log_len,
    output reg forbidden
);
    // feature_on bits: 0 error log, 1 self test, 2 power, 3 queuing,
    // 4 link counters, 5 queue mgmt, 6 streaming, 7 rebuild assist
    always @* begin
        known = 1'b1;
        feat_ok = 1'b1;
        log_len = 17'h00001;
        forbidden = 1'b0;
        case (log_addr)
            `QRL_LOG_DIR: begin
                feat_ok = 1'b1;
            end
            `QRL_LOG_ERR: begin
                feat_ok = feature_on[0];
            end
            `QRL_LOG_STSHORT: begin
                forbidden = 1'b1;
            end
            `QRL_LOG_STEXT: begin
                feat_ok = feature_on[1];
            end
            `QRL_LOG_POWER: begin
                feat_ok = feature_on[2];
            end
            `QRL_LOG_QERR: begin
                feat_ok = feature_on[3];
            end
            `QRL_LOG_LINK: begin
                feat_ok = feature_on[4];
            end
            `QRL_LOG_QMGMT: begin
                feat_ok = feature_on[5];
            end
            `QRL_LOG_REBUILD: begin
                feat_ok = feature_on[7];
            end
            `QRL_LOG_WSTRM, `QRL_LOG_RSTRM: begin
                feat_ok = feature_on[6];
            end
            `QRL_LOG_IDENT: begin
                feat_ok = 1'b1;
            end
            default: begin
                // host pages, else reserved / unknown
                if (log_addr >= `QRL_LOG_HOST_LO && log_addr <= `QRL_LOG_HOST_HI) begin
                    log_len = `QRL_HOST_LOG_LEN;
                end else begin
                    known = 1'b0;
                    feat_ok = 1'b0;
                end
            end
        endcase
    end
endmodule // qrl_log_map

// *** core/qrl_decoder.v ***
// queued read and log read parameter decoder with avalon register access
//
// Behaviour
// - queued read code 60h reads media
// - transfer count from feature current/previous
// - rebuild request honoured only if enabled
// - priority bits 7-6: normal, isochronous, high
// - high priority served first, deadlines tried
// - 48-bit address from six bytes
// - deadline valid only for isochronous priority
// - fine deadline (n+1) times 10 ms
// - coarse deadline (n+1) times 0.5 s
// - force bit reads from media
// - force clear allows cached data
// - first error address, high byte select
// - log read code 2Fh, interrupt per block
// - log count from sector count bytes
// - log address and offset from registers
// - transfer starts at requested offset
// - fixed log map with host pages
// - log 06h always aborts
// - link log addresses decoded, others reserved
// - abort on unsupported feature or bad values
// - self-test log holds both address forms
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "qrl_defs.vh"
module qrl_decoder (
    input wire clock,
    input wire rst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg cmd_valid,
    output reg cmd_is_log,
    output reg [4:0] queue_tag,
    output reg [1:0] queued_priority,
    output reg rebuild_assist_request,
    output reg force_media_read,
    output reg [47:0] start_addr,
    output reg [16:0] xfer_count,
    output reg [7:0] log_addr,
    output reg [15:0] log_offset,
    output reg deadline_valid,
    output reg deadline_abort,
    output reg cmd_aborted,
    input wire media_error,
    input wire [47:0] media_error_addr,
    input wire block_done,
    output reg block_irq
);
    // reset release through two flops
    reg rst_meta_n;
    reg rst_sync_n;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // command block bytes, current and previous write; device/head keeps only the current write
    reg [7:0] feat_cur, feat_prev;
    reg [7:0] scnt_cur, scnt_prev;
    reg [7:0] snum_cur, snum_prev;
    reg [7:0] clow_cur, clow_prev;
    reg [7:0] chigh_cur, chigh_prev;
    reg [7:0] devhead;
    // control: hob select, rebuild support/enable, deadline abort, features
    reg [15:0] ctrl;
    // status flags
    reg err_flag;
    reg [47:0] err_addr;
    reg deadline_expired;
    // deadline timer state
    // wide enough for the longest coarse limit at this clock
    reg [33:0] limit_cycles;
    reg [33:0] deadline_cnt;
    reg deadline_run;
    // set in the cycle after a read was captured
    reg rd_hold;

    wire wr_en = avs_write & ~avs_read;
    wire rd_en = avs_read & ~avs_write;
    // reads wait one cycle so data stand when waitrequest drops
    assign avs_waitrequest = rd_en & ~rd_hold;

    // read wait state flag
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_hold <= 1'b0;
        end else begin
            rd_hold <= rd_en & ~rd_hold;
        end
    end

    // 16-bit counts: zero means 65536
    function [16:0] count16;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if ({hi, lo} == 16'h0000) begin
                count16 = 17'h10000;
            end else begin
                count16 = {1'b0, hi, lo};
            end
        end
    endfunction

    // deadline in cycles from the completion code
    function [33:0] icc_cycles;
        input [7:0] code;
        reg [33:0] units;
        begin
            units = {27'h0000000, code[6:0]} + 34'h000000001;
            if (code[`QRL_ICC_COARSE_BIT]) begin
                icc_cycles = units * (`QRL_COARSE_MS * `QRL_CYC_PER_MS);
            end else begin
                icc_cycles = units * (`QRL_FINE_MS * `QRL_CYC_PER_MS);
            end
        end
    endfunction

    // log map lookup on the selected log address
    wire map_known;
    wire map_feat_ok;
    wire [16:0] map_len;
    wire map_forbidden;
    qrl_log_map u_map (
        .log_addr(snum_cur),
        .feature_on(ctrl[`QRL_CTRL_FEAT_HI:`QRL_CTRL_FEAT_LO]),
        .known(map_known),
        .feat_ok(map_feat_ok),
        .log_len(map_len),
        .forbidden(map_forbidden)
    );

    wire [16:0] log_cnt = count16(scnt_prev, scnt_cur);
    wire [16:0] log_off = {1'b0, clow_prev, clow_cur};
    // range check of count and offset
    wire log_range_bad = (log_off >= map_len) || ((log_off + log_cnt) > {1'b0, map_len});
    wire log_abort = map_forbidden | ~map_known | ~map_feat_ok | log_range_bad;

    wire cmd_write = wr_en && avs_address == `QRL_REG_CMD;
    wire is_qread = avs_writedata[7:0] == `QRL_CMD_QUEUED_READ;
    wire is_lread = avs_writedata[7:0] == `QRL_CMD_LOG_READ;
    wire [1:0] queued_priority_in = scnt_prev[`QRL_QUEUED_PRIORITY_HI:`QRL_QUEUED_PRIORITY_LO];

    // command block byte writes shift current into previous; devhead and ctrl load directly
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            feat_cur <= 8'h00;
            feat_prev <= 8'h00;
            scnt_cur <= 8'h00;
            scnt_prev <= 8'h00;
            snum_cur <= 8'h00;
            snum_prev <= 8'h00;
            clow_cur <= 8'h00;
            clow_prev <= 8'h00;
            chigh_cur <= 8'h00;
            chigh_prev <= 8'h00;
            devhead <= 8'h00;
            ctrl <= `QRL_CTRL_RESET;
        end else if (wr_en) begin
            case (avs_address)
                `QRL_REG_FEAT: begin
                    feat_prev <= feat_cur;
                    feat_cur <= avs_writedata[7:0];
                end
                `QRL_REG_SCNT: begin
                    scnt_prev <= scnt_cur;
                    scnt_cur <= avs_writedata[7:0];
                end
                `QRL_REG_SNUM: begin
                    snum_prev <= snum_cur;
                    snum_cur <= avs_writedata[7:0];
                end
                `QRL_REG_CLOW: begin
                    clow_prev <= clow_cur;
                    clow_cur <= avs_writedata[7:0];
                end
                `QRL_REG_CHIGH: begin
                    chigh_prev <= chigh_cur;
                    chigh_cur <= avs_writedata[7:0];
                end
                `QRL_REG_DEVHEAD: begin
                    devhead <= avs_writedata[7:0];
                end
                `QRL_REG_CTRL: begin
                    ctrl <= avs_writedata[15:0];
                end
                default: begin
                    // other offsets hold no writable state
                end
            endcase
        end
    end

    // command issue: latch decoded parameters
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmd_valid <= 1'b0;
            cmd_is_log <= 1'b0;
            queue_tag <= 5'h00;
            queued_priority <= 2'h0;
            rebuild_assist_request <= 1'b0;
            force_media_read <= 1'b0;
            start_addr <= 48'h000000000000;
            xfer_count <= 17'h00000;
            log_addr <= 8'h00;
            log_offset <= 16'h0000;
            deadline_valid <= 1'b0;
            limit_cycles <= 34'h000000000;
            cmd_aborted <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (cmd_write && is_qread) begin
                cmd_valid <= 1'b1;
                cmd_is_log <= 1'b0;
                cmd_aborted <= 1'b0;
                queue_tag <= scnt_cur[`QRL_TAG_HI:`QRL_TAG_LO];
                xfer_count <= count16(feat_prev, feat_cur);
                rebuild_assist_request <= scnt_cur[`QRL_RBA_BIT]
                    & ctrl[`QRL_CTRL_RBA_SUP_BIT] & ctrl[`QRL_CTRL_RBA_EN_BIT];
                queued_priority <= queued_priority_in;
                force_media_read <= devhead[`QRL_FUA_BIT];
                start_addr <= {chigh_prev, clow_prev, snum_prev,
                               chigh_cur, clow_cur, snum_cur};
                deadline_valid <= queued_priority_in == `QRL_QUEUED_PRIORITY_ISOCH;
                limit_cycles <= icc_cycles(feat_cur);
            end else if (cmd_write && is_lread) begin
                cmd_is_log <= 1'b1;
                deadline_valid <= 1'b0;
                xfer_count <= log_cnt;
                log_addr <= snum_cur;
                log_offset <= clow_cur | {clow_prev, 8'h00};
                cmd_aborted <= log_abort;
                cmd_valid <= ~log_abort;
            end
        end
    end

    // isochronous deadline timer
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            deadline_cnt <= 34'h000000000;
            deadline_run <= 1'b0;
            deadline_expired <= 1'b0;
            deadline_abort <= 1'b0;
        end else begin
            deadline_abort <= 1'b0;
            if (cmd_valid && deadline_valid && !cmd_is_log) begin
                deadline_cnt <= limit_cycles;
                deadline_run <= 1'b1;
                deadline_expired <= 1'b0;
            end else if (deadline_run && block_done && !cmd_is_log) begin
                // a block finished, stop counting
                deadline_run <= 1'b0;
            end else if (deadline_run) begin
                if (deadline_cnt <= 34'h000000001) begin
                    deadline_run <= 1'b0;
                    deadline_expired <= 1'b1;
                    deadline_abort <= ctrl[`QRL_CTRL_DLABORT_BIT];
                end else begin
                    deadline_cnt <= deadline_cnt - 34'h000000001;
                end
            end
        end
    end

    // error capture and per-block interrupt
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_flag <= 1'b0;
            err_addr <= 48'h000000000000;
            block_irq <= 1'b0;
        end else begin
            block_irq <= block_done & cmd_is_log;
            if (media_error && !err_flag) begin
                err_flag <= 1'b1;
                err_addr <= media_error_addr;
            end else if (cmd_write && is_qread) begin
                err_flag <= 1'b0;
            end
        end
    end

    // read mux; hob selects upper error bytes
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_en && !rd_hold) begin
            case (avs_address)
                `QRL_REG_FEAT: avs_readdata <= {16'h0000, feat_prev, feat_cur};
                `QRL_REG_SCNT: avs_readdata <= {16'h0000, scnt_prev, scnt_cur};
                `QRL_REG_SNUM: avs_readdata <= {16'h0000, snum_prev, snum_cur};
                `QRL_REG_CLOW: avs_readdata <= {16'h0000, clow_prev, clow_cur};
                `QRL_REG_CHIGH: avs_readdata <= {16'h0000, chigh_prev, chigh_cur};
                `QRL_REG_DEVHEAD: avs_readdata <= {24'h000000, devhead};
                `QRL_REG_CTRL: avs_readdata <= {16'h0000, ctrl};
                `QRL_REG_STATUS: begin
                    avs_readdata <= {27'h0000000, deadline_expired, deadline_run,
                                     cmd_aborted, cmd_is_log, err_flag};
                end
                `QRL_REG_ERRADDR: begin
                    if (ctrl[`QRL_CTRL_HOB_BIT]) begin
                        avs_readdata <= {8'h00, err_addr[47:24]};
                    end else begin
                        avs_readdata <= {8'h00, err_addr[23:0]};
                    end
                end
                `QRL_REG_LOGINFO: avs_readdata <= {15'h0000, map_len};
                `QRL_REG_LIMIT: avs_readdata <= limit_cycles[31:0];
                `QRL_REG_DEADLINE: avs_readdata <= deadline_cnt[31:0];
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end
    // self-test log content is kept by the back end
endmodule // qrl_decoder

// *** verification/qrl_decoder_sva.sv ***
// port-level assertions for the queued read and log read decoder
`timescale 1ns/1ps
module qrl_decoder_sva (
    input wire clock,
    input wire rst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire cmd_valid,
    input wire cmd_is_log,
    input wire cmd_aborted,
    input wire [1:0] queued_priority,
    input wire deadline_valid,
    input wire block_done,
    input wire block_irq
);
    // shadow of the current sector number byte, the selected log
    reg [7:0] snum_cur;
    // follow host writes to the sector number register
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            snum_cur <= 8'h00;
        end else if (avs_write && avs_address == 4'h2) begin
            snum_cur <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // a command code written to the command register
    sequence s_cmd_wr(code);
        avs_write && !avs_read && avs_address == 4'h6 && avs_writedata[7:0] == code;
    endsequence
    // log read of the forbidden self-test page
    sequence s_log_short;
        s_cmd_wr(8'h2F) ##0 (snum_cur == 8'h06);
    endsequence
    // log read of a reserved link log address
    sequence s_log_reserved;
        s_cmd_wr(8'h2F) ##0 (snum_cur inside {8'h13, 8'h14, 8'h16, 8'h17});
    endsequence
    chk_qread_issue: assert property (
        s_cmd_wr(8'h60) |=> cmd_valid && !cmd_is_log && !cmd_aborted)
        else $error("queued read not issued");
    chk_log_reply: assert property (
        s_cmd_wr(8'h2F) |=> cmd_is_log && (cmd_valid != cmd_aborted))
        else $error("log read neither accepted nor refused");
    chk_log_short_abort: assert property (
        s_log_short |=> cmd_aborted && !cmd_valid)
        else $error("self-test page read not aborted");
    chk_reserved_abort: assert property (
        s_log_reserved |=> cmd_aborted && !cmd_valid)
        else $error("reserved log read not aborted");
    chk_cmd_cause: assert property (
        cmd_valid |-> $past(avs_write && avs_address == 4'h6
            && (avs_writedata[7:0] == 8'h60 || avs_writedata[7:0] == 8'h2F)))
        else $error("command issued without a command write");
    chk_queued_priority_deadline: assert property (
        cmd_valid && !cmd_is_log |-> deadline_valid == (queued_priority == 2'h1))
        else $error("deadline validity does not follow priority");
    chk_irq_per_block: assert property (
        block_done && cmd_is_log |=> block_irq)
        else $error("no interrupt after log block");
    chk_irq_cause: assert property (
        block_irq |-> $past(block_done && cmd_is_log))
        else $error("interrupt without a log block");
    chk_abort_holds: assert property (
        $fell(cmd_aborted) |-> $past(avs_write && avs_address == 4'h6))
        else $error("abort dropped without a new command");
endmodule // qrl_decoder_sva
bind qrl_decoder qrl_decoder_sva u_qrl_decoder_sva (.*);

// *** verification/qrl_backend_model.sv ***
// media and cache back end model answering issued commands
`timescale 1ns/1ps
module qrl_backend_model (
    input wire clock,
    input wire rst_n,
    input wire cmd_valid,
    input wire cmd_is_log,
    input wire [16:0] xfer_count,
    input wire [47:0] start_addr,
    input wire serve,
    input wire err_en,
    input wire [3:0] err_idx,
    input wire [3:0] gap,
    output reg media_error,
    output reg [47:0] media_error_addr,
    output reg block_done
);
    reg [16:0] left; // sectors still to move
    reg [16:0] idx; // sector index within the command
    reg [3:0] wait_n; // stall cycles before the next sector
    reg [47:0] base; // first sector of the command
    reg is_log; // command in flight is a log read
    // one block per sector, with gap stall cycles between them
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            left <= 17'h00000;
            idx <= 17'h00000;
            wait_n <= 4'h0;
            base <= 48'h000000000000;
            is_log <= 1'b0;
            media_error <= 1'b0;
            media_error_addr <= 48'h000000000000;
            block_done <= 1'b0;
        end else begin
            block_done <= 1'b0;
            media_error <= 1'b0;
            // idle address lines toggle
            media_error_addr <= ~media_error_addr;
            if (cmd_valid && serve) begin
                left <= xfer_count;
                idx <= 17'h00000;
                wait_n <= gap;
                base <= start_addr;
                is_log <= cmd_is_log;
            end else if (left != 17'h00000) begin
                if (wait_n != 4'h0) begin
                    wait_n <= wait_n - 4'h1;
                end else if (err_en && !is_log && idx[3:0] == err_idx) begin
                    media_error <= 1'b1;
                    media_error_addr <= base + idx;
                    left <= 17'h00000;
                end else begin
                    block_done <= 1'b1;
                    idx <= idx + 17'h00001;
                    left <= left - 17'h00001;
                    wait_n <= gap;
                end
            end
        end
    end
endmodule // qrl_backend_model

// *** verification/test_qrl_decoder.sv ***
// self-checking bench for the queued read and log read decoder
`timescale 1ns/1ps
`include "qrl_defs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_qrl_decoder;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] avs_address = 4'h0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h00000000;
    reg serve = 1'b0;
    reg err_en = 1'b0;
    reg [3:0] err_idx = 4'h0;
    reg [3:0] gap = 4'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, cmd_valid, cmd_is_log, rebuild_assist_request, force_media_read;
    wire deadline_valid, deadline_abort, cmd_aborted, media_error, block_done, block_irq;
    wire [4:0] queue_tag;
    wire [1:0] queued_priority;
    wire [47:0] start_addr, media_error_addr;
    wire [16:0] xfer_count;
    wire [7:0] log_addr;
    wire [15:0] log_offset;
    int n_errors = 0;
    int cmp_count = 0;
    int irq_n = 0; // interrupts seen so far
    reg [31:0] seed = 32'h8DE4;
    reg [31:0] q; // last read data
    qrl_decoder u_qrl_decoder (.*);
    qrl_backend_model u_qrl_backend_model (.*);
    // 200 MHz clock
    always #2.5 clock = ~clock;
    // count interrupt pulses
    always @(posedge clock) begin
        if (block_irq === 1'b1) irq_n <= irq_n + 1;
    end
    function automatic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // a zero count means 65536 sectors
    function automatic [16:0] cnt17(input [7:0] hi, input [7:0] lo);
        return ({hi, lo} == 16'h0000) ? 17'h10000 : {1'b0, hi, lo};
    endfunction
    function automatic [31:0] exp_limit(input [7:0] c);
        return (c[6:0] + 1) * (c[7] ? `QRL_COARSE_MS : `QRL_FINE_MS) * `QRL_CYC_PER_MS;
    endfunction
    // refusal expected for a log read with feature enables f
    function automatic bit log_bad(input [7:0] a, input [7:0] f, input [15:0] off,
        input [16:0] cnt);
        bit ok;
        reg [16:0] len;
        ok = 1'b1;
        len = 17'h00001;
        case (a)
            8'h00, 8'h30: ok = 1'b1;
            8'h03: ok = f[0];
            8'h07: ok = f[1];
            8'h08: ok = f[2];
            8'h10: ok = f[3];
            8'h11: ok = f[4];
            8'h12: ok = f[5];
            8'h21, 8'h22: ok = f[6];
            8'h15: ok = f[7];
            default: if (a >= 8'h80 && a <= 8'h9F) len = 17'h00010; else ok = 1'b0;
        endcase
        return !ok || {1'b0, off} >= len || {1'b0, off} + cnt > len;
    endfunction
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input bit wr, input [3:0] a, input [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        if (!wr) q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // byte register: previous write then current write
    task automatic put(input [3:0] a, input [7:0] p, input [7:0] c);
        bus(1'b1, a, {24'h000000, p});
        bus(1'b1, a, {24'h000000, c});
    endtask
    // write a command and settle into the answer cycle
    task automatic issue(input [7:0] code);
        bus(1'b1, `QRL_REG_CMD, {24'h000000, code});
        #1;
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        int i, k, irq0;
        reg [7:0] fp, fc, sc, sp, dh, f, a;
        reg [1:0] pr;
        reg [47:0] ea;
        reg [15:0] off;
        reg [16:0] cnt;
        bit bad;
        byte la[19] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
            8'h15, 8'h16, 8'h17, 8'h21, 8'h22, 8'h30, 8'h80, 8'h9F, 8'hA0};
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1 `CHK("idle cmd_valid", 1'b0, cmd_valid)
        bus(1'b0, `QRL_REG_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0000FF00, q)
        bus(1'b1, 4'hE, 32'hFFFFFFFF);
        bus(1'b0, 4'hE, 32'h0);
        `CHK("unmapped", 32'h00000000, q)
        for (i = 0; i < 8; i++) begin
            pr = i % 3;
            fp = (i == 0) ? 8'h00 : rnd();
            fc = (i == 0) ? 8'h00 : (pr == 2'h1) ? {i[2], 4'h0, rnd()[2:0]} : rnd();
            sc = rnd();
            sp = {pr, rnd()[5:0]};
            dh = rnd();
            ea = {rnd(), rnd()};
            bus(1'b1, `QRL_REG_CTRL, {16'hFF00 | {i[1:0], 1'b0}});
            put(`QRL_REG_FEAT, fp, fc);
            put(`QRL_REG_SCNT, sp, sc);
            put(`QRL_REG_SNUM, ea[31:24], ea[7:0]);
            put(`QRL_REG_CLOW, ea[39:32], ea[15:8]);
            put(`QRL_REG_CHIGH, ea[47:40], ea[23:16]);
            bus(1'b1, `QRL_REG_DEVHEAD, {24'h000000, dh});
            issue(`QRL_CMD_QUEUED_READ);
            `CHK("cmd_valid", 1'b1, cmd_valid)
            `CHK("xfer_count", cnt17(fp, fc), xfer_count)
            `CHK("queue_tag", sc[7:3], queue_tag)
            `CHK("rebuild", sc[0] & i[0] & i[1], rebuild_assist_request)
            `CHK("priority", pr, queued_priority)
            `CHK("start_addr", ea, start_addr)
            `CHK("deadline_valid", pr == 2'h1, deadline_valid)
            `CHK("force_media", dh[7], force_media_read)
            bus(1'b0, `QRL_REG_FEAT, 32'h0);
            `CHK("feature pair", {fp, fc}, q[15:0])
            if (pr == 2'h1) begin
                bus(1'b0, `QRL_REG_LIMIT, 32'h0);
                `CHK("deadline limit", exp_limit(fc), q)
            end
        end
        // slow back end with an unrecoverable error at sector 2
        serve <= 1'b1;
        err_en <= 1'b1;
        err_idx <= 4'h2;
        gap <= 4'h3;
        ea = {rnd(), rnd()};
        bus(1'b1, `QRL_REG_CTRL, 32'h0000FF00);
        put(`QRL_REG_FEAT, 8'h00, 8'h04);
        put(`QRL_REG_SNUM, ea[31:24], ea[7:0]);
        put(`QRL_REG_CLOW, ea[39:32], ea[15:8]);
        put(`QRL_REG_CHIGH, ea[47:40], ea[23:16]);
        issue(`QRL_CMD_QUEUED_READ);
        repeat (40) @(posedge clock);
        ea = ea + 48'h2;
        bus(1'b0, `QRL_REG_ERRADDR, 32'h0);
        `CHK("err addr low", {8'h00, ea[23:0]}, q)
        bus(1'b1, `QRL_REG_CTRL, 32'h0000FF01);
        bus(1'b0, `QRL_REG_ERRADDR, 32'h0);
        `CHK("err addr high", {8'h00, ea[47:24]}, q)
        bus(1'b0, `QRL_REG_STATUS, 32'h0);
        `CHK("err flag", 1'b1, q[0])
        err_en <= 1'b0;
        gap <= 4'h1;
        for (k = 0; k < 19; k++) begin
            a = la[k];
            f = (k % 3 == 2) ? rnd() : 8'hFF;
            off = (a >= 8'h80) ? 16'(14 + rnd() % 3) : 16'(rnd() % 2);
            cnt = 17'(1 + rnd() % 2);
            bad = log_bad(a, f, off, cnt);
            bus(1'b1, `QRL_REG_CTRL, {16'h0000, f, 8'h00});
            put(`QRL_REG_SCNT, cnt[15:8], cnt[7:0]);
            put(`QRL_REG_SNUM, 8'h00, a);
            put(`QRL_REG_CLOW, off[15:8], off[7:0]);
            irq0 = irq_n;
            issue(`QRL_CMD_LOG_READ);
            `CHK("log aborted", bad, cmd_aborted)
            `CHK("log accepted", !bad, cmd_valid)
            if (!bad) begin
                `CHK("log_addr", a, log_addr)
                `CHK("log_offset", off, log_offset)
                `CHK("log count", cnt, xfer_count)
                repeat (20) @(posedge clock);
                #1 `CHK("log irqs", cnt, 17'(irq_n - irq0))
            end
        end
        tally_and_finish();
    end
endmodule // test_qrl_decoder
